// [logic/spi_register_access_pkg.sv]
// Package: constants shared by the SPI register access slave and its buffer.
// Assumes a 40 MHz core clock and a slower serial clock from the master.
package spi_register_access_pkg;
    // Word geometry
    localparam int WORD_BITS = 16;
    localparam int INDEX_BITS = 5;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] LAST_BIT_COUNT = 4'hf;

    // Command word fields
    localparam int CMD_DIR_BIT = 15;
    localparam int CMD_PAGE_HI = 13;
    localparam int CMD_PAGE_LO = 12;
    localparam int CMD_FIRST_HI = 10;
    localparam int CMD_FIRST_LO = 6;
    localparam int CMD_LAST_HI = 4;
    localparam int CMD_LAST_LO = 0;

    // Page codes; the two upper codes are reserved
    localparam logic [1:0] PAGE_CODE_0 = 2'h0;
    localparam logic [1:0] PAGE_CODE_1 = 2'h1;

    // Implemented locations per page, one bit per index
    localparam logic [31:0] PAGE0_MAP = 32'h0000_07ff;
    localparam logic [31:0] PAGE1_MAP = 32'h403f_ffff;

    // Reset values
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

    // Write entry: page bit, index, data
    localparam int ENTRY_BITS = 1 + INDEX_BITS + WORD_BITS;
    localparam int BUFFER_DEPTH = 2;

    typedef enum logic [1:0] {
        st_idle,
        st_cmd,
        st_data,
        st_drain
    } link_state_e;
endpackage : spi_register_access_pkg

// [logic/spi_register_access_slave.sv]
// SPI slave front end: command decode and auto-incrementing register streaming.
// Assumes the master clocks far slower than core_clk_in (eight core cycles
// per serial clock or more) and a register file that answers reads one core cycle after the index.
module spi_register_access_slave #(
    parameter logic [31:0] PAGE0_VALID = spi_register_access_pkg::PAGE0_MAP,
    parameter logic [31:0] PAGE1_VALID = spi_register_access_pkg::PAGE1_MAP
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic ss_n_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    output logic busy_out,
    output logic rd_page_out,
    output logic [4:0] rd_index_out,
    output logic rd_strobe_out,
    input wire logic [15:0] rd_data_in,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic wr_page_out,
    output logic [4:0] wr_index_out,
    output logic [15:0] wr_data_out
);
    localparam int WB = spi_register_access_pkg::WORD_BITS;
    localparam int IB = spi_register_access_pkg::INDEX_BITS;
    localparam int EB = spi_register_access_pkg::ENTRY_BITS;

    // Pin synchronisers: index 0 serial clock, 1 data in, 2 select
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic sclk_prev_r;
    logic sclk_s;
    logic mosi_s;
    logic ss_low;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r <= 3'h4;
            sync_r <= 3'h4;
            sclk_prev_r <= 1'b0;
        end else begin
            meta_r <= {ss_n_in, mosi_in, sclk_in};
            sync_r <= meta_r;
            sclk_prev_r <= sync_r[0];
        end
    end

    assign sclk_s = sync_r[0];
    assign mosi_s = sync_r[1];
    assign ss_low = !sync_r[2];
    // Edges only count while selected, so a parked clock is harmless
    assign sclk_rise = ss_low && sclk_s && !sclk_prev_r;
    assign sclk_fall = ss_low && !sclk_s && sclk_prev_r;

    // Transfer state
    spi_register_access_pkg::link_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [WB-1:0] rx_r;
    logic [WB-1:0] rx_word;
    logic word_done;
    logic dir_read_r;
    logic [1:0] page_r;
    logic [IB-1:0] addr_r;
    logic [IB-1:0] last_r;
    logic single_r;
    logic page_ok;
    logic loc_ok;
    logic [31:0] page_map;

    assign rx_word = {rx_r[WB-2:0], mosi_s};
    // A word only completes on its sixteenth falling edge
    assign word_done = sclk_fall && (bit_cnt_r == spi_register_access_pkg::LAST_BIT_COUNT);
    assign page_ok = (page_r == spi_register_access_pkg::PAGE_CODE_0) ||
                     (page_r == spi_register_access_pkg::PAGE_CODE_1);
    assign page_map = (page_r == spi_register_access_pkg::PAGE_CODE_1) ? PAGE1_VALID : PAGE0_VALID;
    assign loc_ok = page_ok && page_map[addr_r];

    // Bit counter and receive shifter; select high clears the count
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_r <= spi_register_access_pkg::BIT_COUNT_RESET;
            rx_r <= spi_register_access_pkg::ZERO_WORD;
        end else if (!ss_low) begin
            bit_cnt_r <= spi_register_access_pkg::BIT_COUNT_RESET;
        end else if (sclk_fall) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            rx_r <= rx_word; // MSB first
        end
    end

    // Command decode and range walk
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= spi_register_access_pkg::st_idle;
            dir_read_r <= 1'b0;
            page_r <= spi_register_access_pkg::PAGE_CODE_0;
            addr_r <= '0;
            last_r <= '0;
            single_r <= 1'b0;
        end else if (!ss_low) begin
            state_r <= spi_register_access_pkg::st_idle;
        end else begin
            unique case (state_r)
                spi_register_access_pkg::st_idle: begin
                    state_r <= spi_register_access_pkg::st_cmd;
                end
                spi_register_access_pkg::st_cmd: begin
                    if (word_done) begin
                        // Bits 14, 11 and 5 are never looked at
                        dir_read_r <= rx_word[spi_register_access_pkg::CMD_DIR_BIT];
                        page_r <= rx_word[spi_register_access_pkg::CMD_PAGE_HI:
                                          spi_register_access_pkg::CMD_PAGE_LO];
                        addr_r <= rx_word[spi_register_access_pkg::CMD_FIRST_HI:
                                          spi_register_access_pkg::CMD_FIRST_LO];
                        last_r <= rx_word[spi_register_access_pkg::CMD_LAST_HI:
                                          spi_register_access_pkg::CMD_LAST_LO];
                        single_r <= rx_word[spi_register_access_pkg::CMD_LAST_HI:
                                            spi_register_access_pkg::CMD_LAST_LO] <=
                                    rx_word[spi_register_access_pkg::CMD_FIRST_HI:
                                            spi_register_access_pkg::CMD_FIRST_LO];
                        state_r <= spi_register_access_pkg::st_data;
                    end
                end
                spi_register_access_pkg::st_data: begin
                    if (word_done) begin
                        if (single_r || addr_r == last_r) begin
                            state_r <= spi_register_access_pkg::st_drain;
                        end else begin
                            addr_r <= addr_r + 1'b1;
                        end
                    end
                end
                spi_register_access_pkg::st_drain: begin
                    state_r <= spi_register_access_pkg::st_drain;
                end
            endcase
        end
    end

    // Read side: address follows the walk, data is registered before use
    logic [WB-1:0] rd_data_r;
    logic [WB-1:0] tx_r;
    logic [WB-1:0] load_word;
    logic read_live;

    assign read_live = dir_read_r && (state_r == spi_register_access_pkg::st_data);
    assign load_word = (read_live && loc_ok) ? rd_data_r
                                             : spi_register_access_pkg::ZERO_WORD;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_r <= spi_register_access_pkg::ZERO_WORD;
            rd_page_out <= 1'b0;
            rd_index_out <= '0;
            rd_strobe_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            rd_data_r <= rd_data_in;
            rd_page_out <= page_r[0];
            rd_index_out <= addr_r;
            // Strobe marks the word actually taken, for read-sensitive registers
            rd_strobe_out <= sclk_rise && read_live && loc_ok &&
                             (bit_cnt_r == spi_register_access_pkg::BIT_COUNT_RESET);
            busy_out <= ss_low;
        end
    end

    // Transmit shifter: a word is loaded at its first rising edge
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_r <= spi_register_access_pkg::ZERO_WORD;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end else if (!ss_low) begin
            miso_oe_n_out <= 1'b1;
            miso_out <= 1'b0;
        end else begin
            miso_oe_n_out <= 1'b0;
            if (sclk_rise) begin
                if (bit_cnt_r == spi_register_access_pkg::BIT_COUNT_RESET) begin
                    miso_out <= load_word[WB-1];
                    tx_r <= {load_word[WB-2:0], 1'b0};
                end else begin
                    miso_out <= tx_r[WB-1];
                    tx_r <= {tx_r[WB-2:0], 1'b0};
                end
            end
        end
    end

    // Write side: whole words only, held until the buffer takes them or the next completed word replaces them
    logic pend_r;
    logic [EB-1:0] pend_entry_r;
    logic buf_ready;
    logic write_word;

    assign write_word = word_done && !dir_read_r &&
                        (state_r == spi_register_access_pkg::st_data) && loc_ok;

    // A stall by the register file holds the word until the buffer takes it or the next completed word overwrites it
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_r <= 1'b0;
            pend_entry_r <= '0;
        end else if (write_word) begin
            pend_r <= 1'b1;
            pend_entry_r <= {page_r[0], addr_r, rx_word};
        end else if (buf_ready) begin
            pend_r <= 1'b0;
        end
    end

    word_buffer #(
        .WIDTH(EB),
        .DEPTH(spi_register_access_pkg::BUFFER_DEPTH)
    ) u_write_buffer (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(pend_r),
        .in_data_in(pend_entry_r),
        .in_ready_out(buf_ready),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in),
        .out_data_out({wr_page_out, wr_index_out, wr_data_out})
    );

    // Falls since select fell, kept apart from the bit counter so the checks can trust it
    logic [4:0] falls_seen_r;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            falls_seen_r <= '0;
        end else if (!ss_low) begin
            falls_seen_r <= '0;
        end else if (sclk_fall) begin
            falls_seen_r <= falls_seen_r + 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_float_deselect: assert property (!ss_low |=> miso_oe_n_out)
        else $error("data output driven while deselected");
    a_cmd_first: assert property (
        state_r == spi_register_access_pkg::st_idle && ss_low
        |=> state_r == spi_register_access_pkg::st_cmd)
        else $error("first word after select not taken as command");
    a_abort_idle: assert property (
        $rose(sync_r[2]) |=> state_r == spi_register_access_pkg::st_idle
        && bit_cnt_r == spi_register_access_pkg::BIT_COUNT_RESET)
        else $error("transfer resumed after abort");
    a_sixteen_bits: assert property (
        state_r == spi_register_access_pkg::st_cmd && word_done
        |-> falls_seen_r == {1'b0, spi_register_access_pkg::LAST_BIT_COUNT})
        else $error("command completed on wrong bit");
    a_partial_no_write: assert property (
        pend_r && !$past(pend_r)
        |-> $past(bit_cnt_r) == spi_register_access_pkg::LAST_BIT_COUNT && $past(sclk_fall))
        else $error("write issued from partial word");
    a_drain_range: assert property (
        state_r == spi_register_access_pkg::st_data && word_done && addr_r == last_r
        |=> state_r == spi_register_access_pkg::st_drain)
        else $error("range end not reached");
    a_addr_step: assert property (
        state_r == spi_register_access_pkg::st_data && word_done && !single_r && addr_r != last_r
        |=> addr_r == $past(addr_r) + 5'h01)
        else $error("address did not advance by one");
    a_drain_zero: assert property (
        state_r == spi_register_access_pkg::st_drain && dir_read_r && sclk_rise && ss_low
        |=> !miso_out)
        else $error("nonzero data after range end");
    a_reserved_silent: assert property (
        state_r == spi_register_access_pkg::st_data && !page_ok
        |=> !(pend_r && !$past(pend_r)))
        else $error("write on reserved page");
    a_single_range: assert property (
        state_r == spi_register_access_pkg::st_cmd && word_done
        && rx_word[4:0] <= rx_word[10:6] |=> single_r)
        else $error("single access not detected");
    a_write_hold: assert property (
        wr_valid_out && !wr_ready_in
        |=> wr_valid_out && $stable({wr_page_out, wr_index_out, wr_data_out}))
        else $error("write entry changed before it was taken");

    c_read_burst: cover property (read_live && word_done && addr_r == last_r && !single_r);
    c_write_burst: cover property (write_word && !single_r && addr_r == last_r);
    c_abort_mid_word: cover property ($rose(sync_r[2]) && bit_cnt_r != 4'h0);
    c_buffer_stall: cover property (pend_r && !buf_ready);
endmodule : spi_register_access_slave

// [logic/word_buffer.sv]
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; full and empty flags are registered.
module word_buffer #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 2
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_BITS:0] FULL_COUNT = (PTR_BITS + 1)'(DEPTH);
    localparam logic [PTR_BITS-1:0] LAST_PTR = PTR_BITS'(DEPTH - 1);

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("word_buffer needs at least two entries");
        end
    endgenerate

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PTR_BITS-1:0] wr_ptr_r;
    logic [PTR_BITS-1:0] rd_ptr_r;
    logic [PTR_BITS:0] count_r;
    logic [PTR_BITS:0] count_nxt;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = store_r[rd_ptr_r];

    // Occupancy; flags follow the next count so they never lag a cycle
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r <= '0;
            out_valid_out <= 1'b0;
            in_ready_out <= 1'b1;
        end else begin
            count_r <= count_nxt;
            out_valid_out <= (count_nxt != '0);
            in_ready_out <= (count_nxt != FULL_COUNT);
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // Storage needs no reset; valid guards it
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data_in;
        end
    end
endmodule : word_buffer

// [test/spi_host_model.sv]
// Host model: SPI master sending frames of 16-bit words, clock polarity 0, phase 1.
// Assumes the bench calls frame() one at a time; it paces a 200 ns link clock off the core clock.
module spi_host_model (
    input wire logic core_clk_in,
    output logic sclk_out,
    output logic mosi_out,
    output logic ss_n_out,
    input wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half of the 200 ns link clock, in 25 ns core cycles
    localparam int HALF_CYCLES = 4;

    // Idle: deselected, serial clock resting low
    initial begin
        sclk_out = 1'b0;
        mosi_out = 1'b0;
        ss_n_out = 1'b1;
    end

    // One select-low period; a word cut short is never handed back
    task automatic frame(input logic [15:0] tx [$], input int nbits, output logic [15:0] rx [$]);
        logic [15:0] sh;
        logic [15:0] w;
        rx = {};
        sh = 16'h0000;
        // Pins move just after a core edge, so no change lands on a sampling edge
        @(posedge core_clk_in);
        ss_n_out <= 1'b0;
        repeat (HALF_CYCLES) @(posedge core_clk_in);
        for (int i = 0; i < nbits; i++) begin
            w = tx[i / 16];
            sclk_out <= 1'b1;
            mosi_out <= w[15 - (i % 16)];
            repeat (HALF_CYCLES) @(posedge core_clk_in);
            sclk_out <= 1'b0;
            sh = {sh[14:0], miso_in};
            if (i % 16 == 15) rx.push_back(sh);
            repeat (HALF_CYCLES) @(posedge core_clk_in);
        end
        ss_n_out <= 1'b1;
        mosi_out <= ~mosi_out; // Released line has no pull, so show a changed level
        repeat (4 * HALF_CYCLES) @(posedge core_clk_in);
    endtask : frame
endmodule : spi_host_model

// [test/testbench.sv]
// Self-checking bench for the SPI register access slave: corner and random frames.
// Assumes the host model drives the link and this bench plays the register file.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_in;
    logic reset_n_in;
    logic sclk_in;
    logic mosi_in;
    logic ss_n_in;
    logic miso_out;
    logic miso_oe_n_out;
    logic miso_wire;
    logic busy_out;
    logic rd_page_out;
    logic [4:0] rd_index_out;
    logic rd_strobe_out;
    logic [15:0] rd_data_in;
    logic wr_valid_out;
    logic wr_ready_in;
    logic wr_page_out;
    logic [4:0] wr_index_out;
    logic [15:0] wr_data_out;
    logic [15:0] regs [2][32];
    logic [21:0] wq [$];
    logic [21:0] rq [$];
    logic stall;
    int miscompares;
    int num_checks;

    // Core clock, 25 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    // The pin floats unless the slave drives it
    assign miso_wire = miso_oe_n_out ? 1'bz : miso_out;

    spi_host_model i_spi_host_model (
        .core_clk_in(core_clk_in),
        .sclk_out(sclk_in), .mosi_out(mosi_in), .ss_n_out(ss_n_in), .miso_in(miso_wire)
    );

    spi_register_access_slave i_spi_register_access_slave (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk_in),
        .mosi_in(mosi_in), .ss_n_in(ss_n_in), .miso_out(miso_out),
        .miso_oe_n_out(miso_oe_n_out), .busy_out(busy_out), .rd_page_out(rd_page_out),
        .rd_index_out(rd_index_out), .rd_strobe_out(rd_strobe_out), .rd_data_in(rd_data_in),
        .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_page_out(wr_page_out),
        .wr_index_out(wr_index_out), .wr_data_out(wr_data_out)
    );

    task automatic chk_word(input string what, input logic [21:0] exp, input logic [21:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    // Register file: read data a cycle behind the index; random stalls on the write side
    always @(posedge core_clk_in) begin
        rd_data_in <= regs[rd_page_out][rd_index_out];
        wr_ready_in <= !stall && ($urandom % 4 != 0);
        if (rd_strobe_out === 1'b1) begin
            chk_word("read index", (rq.size() != 0) ? rq.pop_front() : 'x,
                     {16'h0, rd_page_out, rd_index_out});
        end
        if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1) begin
            regs[wr_page_out][wr_index_out] <= wr_data_out;
            chk_word("write entry", (wq.size() != 0) ? wq.pop_front() : 'x,
                     {wr_page_out, wr_index_out, wr_data_out});
        end
    end

    // Register served by data word k, or -1 where a zero or dropped word is due
    function automatic int slot(input logic [15:0] cmd, input int k);
        int f;
        int l;
        int i;
        logic [31:0] map;
        f = int'(cmd[10:6]);
        l = int'(cmd[4:0]);
        i = f + k - 1;
        map = cmd[12] ? spi_register_access_pkg::PAGE1_MAP : spi_register_access_pkg::PAGE0_MAP;
        if (l < f) l = f;
        if (cmd[13] || i > l || !map[i]) return -1;
        return i;
    endfunction : slot

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Bounded wait for every expected write to leave the buffer
    task automatic drain();
        for (int i = 0; i < 200 && wq.size() != 0; i++) @(posedge core_clk_in);
        if (wq.size() != 0) begin
            miscompares++;
            $display("[FAIL] write drain expected 0 seen %0d", wq.size());
            give_verdict();
        end
    endtask : drain

    // One frame: command, nw data words, the last cut short by cut bits when cut > 0
    task automatic do_frame(input logic [15:0] cmd, input int nw, input int cut);
        logic [15:0] tx [$];
        logic [15:0] rx [$];
        int done;
        int s;
        drain();
        tx.push_back(cmd);
        for (int k = 1; k <= nw; k++) tx.push_back(16'($urandom));
        done = (cut != 0) ? nw - 1 : nw;
        for (int k = 1; k <= done && !cmd[15]; k++) begin
            s = slot(cmd, k);
            if (s >= 0) wq.push_back({cmd[12], 5'(s), tx[k]});
        end
        // A cut read word still loads, so it still strobes
        for (int k = 1; k <= nw && cmd[15]; k++) begin
            s = slot(cmd, k);
            if (s >= 0) rq.push_back({16'h0, cmd[12], 5'(s)});
        end
        i_spi_host_model.frame(tx, 16 * (nw + 1) - cut, rx);
        for (int k = 1; k <= done && cmd[15]; k++) begin
            s = slot(cmd, k);
            chk_word("read word", (s < 0) ? 22'h0 : {6'h0, regs[cmd[12]][s]}, {6'h0, rx[k]});
        end
        repeat (5) @(posedge core_clk_in);
        chk_word("read strobes left", 22'h0, 22'(rq.size()));
        rq.delete();
        chk_flag("miso enable", 1'b1, miso_oe_n_out);
        chk_flag("busy", 1'b0, busy_out);
    endtask : do_frame

    // Main sequence: reset, corner frames, then random frames
    initial begin
        logic [15:0] cmd;
        void'($urandom(34954));
        reset_n_in = 1'b0;
        stall = 1'b0;
        miscompares = 0;
        num_checks = 0;
        foreach (regs[p, i]) regs[p][i] = 16'($urandom);
        repeat (4) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        chk_flag("idle enable", 1'b1, miso_oe_n_out);
        do_frame(16'h8087, 8, 0);
        do_frame(16'hc8a7, 6, 0);
        stall <= 1'b1;
        do_frame(16'h10c5, 5, 0);
        stall <= 1'b0;
        do_frame(16'h90c5, 3, 0);
        do_frame(16'h8000, 3, 0);
        do_frame(16'h0145, 2, 0);
        do_frame(16'h828e, 5, 0);
        do_frame(16'h02cc, 2, 0);
        do_frame(16'ha0c5, 3, 0);
        do_frame(16'h30c5, 3, 0);
        do_frame(16'h1043, 3, 9);
        do_frame(16'h8087, 2, 5);
        do_frame(16'h9043, 3, 0);
        for (int n = 0; n < 12; n++) begin
            cmd = 16'($urandom);
            if ($urandom % 4 != 0) cmd[13] = 1'b0;
            do_frame(cmd, 1 + $urandom % 5, (n % 3 == 0) ? $urandom % 16 : 0);
        end
        drain();
        give_verdict();
    end
endmodule : testbench
